/* File: hw/fcp_pwm_top.sv */
// Four channel PWM unit with its register port and output pin stage.
// Assumes a synchronous register master and loads on the output pins.
//
// Functional notes
// - Four channels, each counter, period, width, compares.
// - Unit runs only with both enable bits set.
// - Edge mode counts up, wraps to zero.
// - Edge mode output high at or above width.
// - Edge period is period value plus one.
// - Width zero full on, above period off.
// - Center mode counts up then down, repeats.
// - Center output high while counter at/above width.
// - Center period is twice period plus two.
// - Burst puts channel 0 AND 1 on pin 0.
// - Burst AND result registered to the pin.
// - Polarity XOR per pin, reset non-inverted.
// - Polarity applied after the burst AND.
// - Single shot on 2/3 clears counter, run bit.
// - One pulse per software start in single shot.
// - Counter writes accepted while running, shift edges.
// - Writing period into counter ends the pulse.
// - Counter clock is system clock or divided by 64.
// - Run bit gates only the counter clock.
// - Software starts, hardware or software stops.
// - Shadows load each cycle start or when stopped.
// - Pending flag set by hardware, cleared by software.
// - Disabled output does not drive its pin.
`timescale 1ns/1ps
`default_nettype none
module fcp_pwm_top
(
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        ce,
   input  wire logic [7:0]  regAddr,
   input  wire logic [15:0] regWdata,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic [15:0]      regRdata,
   output logic [3:0]       pwmPin,
   output logic [3:0]       pwmOe
);
   fcp_pkg::fcp_top_s st_q;
   fcp_pkg::fcp_top_s st_d;

   logic             unitEn;
   logic             tick64;
   logic [3:0]       chTick;
   logic [3:0]       chCntWr;
   logic [3:0]       chPerWr;
   logic [3:0]       chWidWr;
   logic [3:0]       chWrap;
   logic [3:0]       chStop;
   logic [3:0]       chPwm;
   logic [3:0][15:0] chCnt;
   logic [3:0]       single;
   logic             grpCnt;
   logic             grpPer;
   logic             grpWid;
   logic [1:0]       chSel;
   logic             wordOk;
   logic             pinSig;

   assign unitEn = st_q.sysEn && st_q.extEn;
   assign chSel  = regAddr[2:1];
   assign wordOk = (regAddr[0] == 1'b0) && (regAddr[3] == 1'b0);
   assign grpCnt = wordOk && (regAddr[7:4] == fcp_pkg::REG_CNT_GRP);
   assign grpPer = wordOk && (regAddr[7:4] == fcp_pkg::REG_PER_GRP);
   assign grpWid = wordOk && (regAddr[7:4] == fcp_pkg::REG_WID_GRP);
   assign single = {st_q.ps, 2'b00};

   fcp_prescaler u_prescaler
   (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .ce      (ce),
      .enable  (unitEn),
      .tick64  (tick64)
   );

   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : g_ch
         fcp_ch_if chIf ();

         // Run gates the count pulse only; output compare stays live.
         assign chTick[g]     = ce && unitEn && st_q.run[g] &&
                                (st_q.tsel[g] ? tick64 : 1'b1);
         assign chCntWr[g]    = regWr && grpCnt && (chSel == g);
         assign chPerWr[g]    = regWr && grpPer && (chSel == g);
         assign chWidWr[g]    = regWr && grpWid && (chSel == g);
         assign chIf.tick     = chTick[g];
         assign chIf.running  = st_q.run[g];
         assign chIf.center   = st_q.pm[g];
         assign chIf.single   = single[g];
         assign chIf.perReg   = st_q.per[g];
         assign chIf.widReg   = st_q.wid[g];
         assign chIf.wrData   = regWdata;
         assign chIf.cntWr    = chCntWr[g];
         assign chIf.perWr    = chPerWr[g];
         assign chIf.widWr    = chWidWr[g];
         assign chCnt[g]      = chIf.cnt;
         assign chPwm[g]      = chIf.pwm;
         assign chWrap[g]     = chIf.wrapEv;
         assign chStop[g]     = chIf.stopReq;

         fcp_channel u_channel
         (
            .clk_sys (clk_sys),
            .rst_n   (rst_n),
            .ce      (ce),
            .chIf    (chIf)
         );
      end
   endgenerate

   always_comb
   begin
      st_d = st_q;
      pinSig = 1'b0;

      // Register writes.
      if (regWr)
      begin
         unique case (regAddr)
            fcp_pkg::OFS_TIMER_CTRL:
            begin
               st_d.run  = regWdata[fcp_pkg::RUN_LSB +: 4];
               st_d.tsel = regWdata[fcp_pkg::TSEL_LSB +: 4];
               st_d.ie   = regWdata[fcp_pkg::IE_LSB +: 4];
               st_d.ir   = regWdata[fcp_pkg::IR_LSB +: 4];
            end
            fcp_pkg::OFS_MODE_CTRL:
            begin
               st_d.pen   = regWdata[fcp_pkg::PEN_LSB +: 4];
               st_d.pm    = regWdata[fcp_pkg::PM_LSB +: 4];
               st_d.burst = regWdata[fcp_pkg::BURST_BIT];
               st_d.ps    = {regWdata[fcp_pkg::PS3_BIT], regWdata[fcp_pkg::PS2_BIT]};
            end
            fcp_pkg::OFS_POLARITY:
            begin
               st_d.pol = regWdata[3:0];
            end
            fcp_pkg::OFS_ENABLE:
            begin
               st_d.sysEn = regWdata[fcp_pkg::SYS_EN_BIT];
               st_d.extEn = regWdata[fcp_pkg::EXT_EN_BIT];
            end
            default:
            begin
               if (grpPer)
               begin
                  st_d.per[chSel] = regWdata;
               end
               if (grpWid)
               begin
                  st_d.wid[chSel] = regWdata;
               end
            end
         endcase
      end

      // Hardware events win over a software clear in the same cycle.
      st_d.ir  = st_d.ir | chWrap;
      // The hardware stop only lands if software did not restart the timer.
      if (!(regWr && (regAddr == fcp_pkg::OFS_TIMER_CTRL)))
      begin
         st_d.run = st_q.run & ~chStop;
      end

      // Read data appear in the cycle after the strobe and only there.
      st_d.rdata = fcp_pkg::RST_REG16;
      if (regRd)
      begin
         unique case (regAddr)
            fcp_pkg::OFS_TIMER_CTRL:
            begin
               st_d.rdata = {st_q.ir, st_q.ie, st_q.tsel, st_q.run};
            end
            fcp_pkg::OFS_MODE_CTRL:
            begin
               st_d.rdata = {4'h0, st_q.ps, 1'b0, st_q.burst, st_q.pm, st_q.pen};
            end
            fcp_pkg::OFS_POLARITY:
            begin
               st_d.rdata = {12'h000, st_q.pol};
            end
            fcp_pkg::OFS_ENABLE:
            begin
               st_d.rdata = {11'h000, st_q.extEn, 1'b0, st_q.sysEn, 2'b00};
            end
            default:
            begin
               if (grpCnt)
               begin
                  st_d.rdata = chCnt[chSel];
               end
               else if (grpPer)
               begin
                  st_d.rdata = st_q.per[chSel];
               end
               else if (grpWid)
               begin
                  st_d.rdata = st_q.wid[chSel];
               end
            end
         endcase
      end

      // Output stage: burst AND first, polarity after it, all registered.
      for (int i = 0; i < 4; i++)
      begin
         pinSig = chPwm[i];
         if ((i == 0) && st_q.burst)
         begin
            pinSig = chPwm[0] && chPwm[1];
         end
         st_d.pin[i] = st_q.pen[i] && (pinSig ^ st_q.pol[i]);
      end

      if (!ce)
      begin
         st_d = st_q;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign regRdata = st_q.rdata;
   assign pwmPin   = st_q.pin;
   assign pwmOe    = st_q.pen;
endmodule // fcp_pwm_top
`default_nettype wire

/* File: hw/fcp_pkg.sv */
// Package of the four channel PWM unit: register offsets, field positions,
// reset values, timing constants and state types.
// Assumes one system clock domain and a 16-bit register port.
package fcp_pkg;

   localparam int unsigned NUM_CH   = 4;
   localparam int unsigned CNT_W    = 16;
   localparam int unsigned ADDR_W   = 8;

   // Register offsets within the unit's address window.
   localparam logic [7:0] OFS_TIMER_CTRL = 8'h00;
   localparam logic [7:0] OFS_MODE_CTRL  = 8'h02;
   localparam logic [7:0] OFS_POLARITY   = 8'h04;
   localparam logic [7:0] OFS_ENABLE     = 8'h06;
   localparam logic [3:0] REG_CNT_GRP    = 4'h1;
   localparam logic [3:0] REG_PER_GRP    = 4'h2;
   localparam logic [3:0] REG_WID_GRP    = 4'h3;

   // Field positions of the timer control register.
   localparam int unsigned RUN_LSB  = 0;
   localparam int unsigned TSEL_LSB = 4;
   localparam int unsigned IE_LSB   = 8;
   localparam int unsigned IR_LSB   = 12;

   // Field positions of the mode control register.
   localparam int unsigned PEN_LSB   = 0;
   localparam int unsigned PM_LSB    = 4;
   localparam int unsigned BURST_BIT = 8;
   localparam int unsigned PS2_BIT   = 10;
   localparam int unsigned PS3_BIT   = 11;

   // Field positions of the enable register.
   localparam int unsigned SYS_EN_BIT = 2;
   localparam int unsigned EXT_EN_BIT = 4;

   localparam logic [15:0] RST_REG16 = 16'h0000;
   localparam logic [3:0]  RST_BITS4 = 4'h0;
   localparam logic [5:0]  PRESCALE_LAST = 6'h3F;  // Divide by 64.

   typedef struct packed {
      logic [5:0] cnt;
   } fcp_pre_s;

   typedef struct packed {
      logic [15:0] cnt;
      logic        down;
      logic [15:0] perSh;
      logic [15:0] widSh;
      logic        pwm;
   } fcp_ch_s;

   typedef struct packed {
      logic [3:0]        run;
      logic [3:0]        tsel;
      logic [3:0]        ie;
      logic [3:0]        ir;
      logic [3:0]        pen;
      logic [3:0]        pm;
      logic              burst;
      logic [1:0]        ps;
      logic [3:0]        pol;
      logic              sysEn;
      logic              extEn;
      logic [3:0][15:0]  per;
      logic [3:0][15:0]  wid;
      logic [3:0]        pin;
      logic [15:0]       rdata;
   } fcp_top_s;

endpackage

/* File: hw/fcp_ch_if.sv */
// Interface joining the register block to one PWM channel.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface fcp_ch_if;
   logic        tick;
   logic        running;
   logic        center;
   logic        single;
   logic [15:0] perReg;
   logic [15:0] widReg;
   logic [15:0] wrData;
   logic        cntWr;
   logic        perWr;
   logic        widWr;
   logic [15:0] cnt;
   logic        pwm;
   logic        wrapEv;
   logic        stopReq;

   modport ctrl (output tick, running, center, single, perReg, widReg, wrData,
                 cntWr, perWr, widWr, input cnt, pwm, wrapEv, stopReq);
   modport chan (input tick, running, center, single, perReg, widReg, wrData,
                 cntWr, perWr, widWr, output cnt, pwm, wrapEv, stopReq);
endinterface
`default_nettype wire

/* File: hw/fcp_prescaler.sv */
// Divide-by-64 count pulse generator shared by all channels.
// Assumes a synchronous clock enable that freezes the divider.
`timescale 1ns/1ps
`default_nettype none
module fcp_prescaler
(
   input  wire logic clk_sys,
   input  wire logic rst_n,
   input  wire logic ce,
   input  wire logic enable,
   output logic      tick64
);
   fcp_pkg::fcp_pre_s st_q;
   fcp_pkg::fcp_pre_s st_d;

   always_comb
   begin
      st_d = st_q;
      if (ce && enable)
      begin
         st_d.cnt = st_q.cnt + 6'h01;
      end
   end

   assign tick64 = ce && enable && (st_q.cnt == fcp_pkg::PRESCALE_LAST);

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end
endmodule // fcp_prescaler
`default_nettype wire

/* File: hw/fcp_channel.sv */
// One PWM channel: counter, period and width shadows, compare output.
// Assumes tick is already gated by the run bit, the unit enable and ce.
`timescale 1ns/1ps
`default_nettype none
module fcp_channel
(
   input  wire logic clk_sys,
   input  wire logic rst_n,
   input  wire logic ce,
   fcp_ch_if.chan    chIf
);
   fcp_pkg::fcp_ch_s st_q;
   fcp_pkg::fcp_ch_s st_d;
   logic             wrap;

   always_comb
   begin
      st_d = st_q;
      wrap = 1'b0;
      if (chIf.tick)
      begin
         if (chIf.center)
         begin
            if (!st_q.down)
            begin
               if (st_q.cnt >= st_q.perSh)
               begin
                  st_d.down = 1'b1;
               end
               else
               begin
                  st_d.cnt = st_q.cnt + 16'h0001;
               end
            end
            else if (st_q.cnt == 16'h0000)
            begin
               st_d.down = 1'b0;
               wrap = 1'b1;
            end
            else
            begin
               st_d.cnt = st_q.cnt - 16'h0001;
            end
         end
         else
         begin
            st_d.down = 1'b0;
            if (st_q.cnt >= st_q.perSh)
            begin
               st_d.cnt = 16'h0000;
               wrap = 1'b1;
            end
            else
            begin
               st_d.cnt = st_q.cnt + 16'h0001;
            end
         end
      end
      if (wrap)
      begin
         st_d.perSh = chIf.perReg;
         st_d.widSh = chIf.widReg;
      end
      // A stopped counter has no cycle boundary, so a write lands at once.
      if (chIf.perWr && !chIf.running)
      begin
         st_d.perSh = chIf.wrData;
      end
      if (chIf.widWr && !chIf.running)
      begin
         st_d.widSh = chIf.wrData;
      end
      if (chIf.cntWr)
      begin
         st_d.cnt = chIf.wrData;
      end
      // Greater-or-equal compare covers both alignments and both duty limits.
      st_d.pwm = (st_d.cnt >= st_d.widSh);
      if (!ce)
      begin
         st_d = st_q;
         wrap = 1'b0;
      end
   end

   assign chIf.cnt     = st_q.cnt;
   assign chIf.pwm     = st_q.pwm;
   assign chIf.wrapEv  = wrap;
   assign chIf.stopReq = wrap && chIf.single;

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end
endmodule // fcp_channel
`default_nettype wire

/* File: testbench/fcp_load_model.sv */
// Load model on the PWM pins: counts high samples and rising edges.
// Assumes an undriven pin reads low, as with a pull-down at the load.
`timescale 1ns/1ps
`default_nettype none
module fcp_load_model
(
   input  wire logic            clk_sys,
   input  wire logic            clr,
   input  wire logic [3:0]      pin,
   input  wire logic [3:0]      oe,
   output logic      [3:0][8:0] hi,
   output logic      [3:0][8:0] rs
);
   logic [3:0] lvl;
   logic [3:0] prv;
   assign lvl = pin & oe;
   always_ff @(posedge clk_sys)
   begin
      prv <= lvl;
      for (int i = 0; i < 4; i++)
      begin
         hi[i] <= clr ? 9'h000 : hi[i] + 9'(lvl[i]);
         rs[i] <= clr ? 9'h000 : rs[i] + 9'(lvl[i] & ~prv[i]);
      end
   end
endmodule // fcp_load_model
`default_nettype wire

/* File: testbench/fcp_pwm_sva.sv */
// Checker on the ports of the four channel PWM unit.
// Assumes the unit sits alone on its register port.
`timescale 1ns/1ps
`default_nettype none
module fcp_pwm_sva
(
   input wire logic        clk_sys,
   input wire logic        rst_n,
   input wire logic        ce,
   input wire logic [7:0]  regAddr,
   input wire logic [15:0] regWdata,
   input wire logic        regWr,
   input wire logic        regRd,
   input wire logic [15:0] regRdata,
   input wire logic [3:0]  pwmPin,
   input wire logic [3:0]  pwmOe
);
   logic [3:0] polQ;
   logic       enQ;
   logic [2:0] wrHQ;
   // Write history lets the idle check wait until a write has settled.
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         polQ <= 4'h0;
         enQ  <= 1'b0;
         wrHQ <= 3'h0;
      end
      else if (ce)
      begin
         wrHQ <= {wrHQ[1:0], regWr};
         if (regWr && regAddr == 8'h04)
            polQ <= regWdata[3:0];
         if (regWr && regAddr == 8'h06)
            enQ <= regWdata[2] & regWdata[4];
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n || !ce);
   rd_idle_a: assert property (!$past(regRd) |-> regRdata == 16'h0000)
      else $error("read data not zero");
   odd_read_a: assert property ($past(regRd && regAddr[0]) |-> regRdata == 16'h0000)
      else $error("odd read not zero");
   pol_read_a: assert property (
      $past(regRd && regAddr == 8'h04) |-> regRdata == {12'h000, $past(polQ)})
      else $error("polarity read wrong");
   oe_write_a: assert property (
      $past(regWr && regAddr == 8'h02) |-> pwmOe == $past(regWdata[3:0]))
      else $error("enable not taken");
   oe_hold_a: assert property (!$past(regWr && regAddr == 8'h02) |-> $stable(pwmOe))
      else $error("enable changed");
   pin_off_a: assert property ((~pwmOe & ~$past(pwmOe) & pwmPin) == 4'h0)
      else $error("disabled pin high");
   idle_frozen_a: assert property (!enQ && wrHQ == 3'h0 |=> $stable(pwmPin))
      else $error("pin moved while off");
   rst_pins_a: assert property (
      $rose(rst_n) |-> pwmPin == 4'h0 && pwmOe == 4'h0 && regRdata == 16'h0000)
      else $error("outputs not clear");
   cover property ($rose(pwmPin[0]));
   cover property ($past(regRd) && regRdata != 16'h0000);
   cover property (pwmOe[0] && pwmOe[1]);
endmodule // fcp_pwm_sva
bind fcp_pwm_top fcp_pwm_sva fcp_pwm_sva_i (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
   .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
   .regRdata(regRdata), .pwmPin(pwmPin), .pwmOe(pwmOe));
`default_nettype wire

/* File: testbench/tb_top.sv */
// Testbench of the four channel PWM unit with loads on its pins.
// Assumes the unit has one clock; ce drops only in the freeze scenario.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic            clk_sys = 1'b0;
   logic            rst_n;
   logic            ce;
   logic [7:0]      regAddr;
   logic [15:0]     regWdata;
   logic            regWr;
   logic            regRd;
   logic [15:0]     regRdata;
   logic [3:0]      pwmPin;
   logic [3:0]      pwmOe;
   logic            clr;
   logic [3:0][8:0] hi;
   logic [3:0][8:0] rs;
   int              failures = 0;
   int              num_checks = 0;
   always #10 clk_sys = ~clk_sys;
   fcp_pwm_top fcp_pwm_top_i (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .pwmPin(pwmPin), .pwmOe(pwmOe));
   fcp_load_model fcp_load_model_i (.clk_sys(clk_sys), .clr(clr), .pin(pwmPin),
      .oe(pwmOe), .hi(hi), .rs(rs));
   task automatic test_done;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e)
      begin
         failures++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk_sys);
      regWr <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk_sys);
      regRd <= 1'b0;
      #1 chk("regRdata", e, regRdata);
      @(posedge clk_sys);
   endtask
   task automatic cfg(input int c, input logic [15:0] p, input logic [15:0] w);
      wr(8'(16 + 2 * c), 16'h0000);
      wr(8'(32 + 2 * c), p);
      wr(8'(48 + 2 * c), w);
   endtask
   task automatic mstart;
      @(posedge clk_sys);
      clr <= 1'b1;
      @(posedge clk_sys);
      clr <= 1'b0;
   endtask
   task automatic mend(input int n);
      repeat (n) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask
   task automatic meas(input int n);
      repeat (8) @(posedge clk_sys);
      mstart;
      mend(n);
   endtask
   task automatic ck(input int c, input logic [15:0] h, input logic [15:0] r);
      chk("loadHigh", h, 16'(hi[c]));
      chk("loadRise", r, 16'(rs[c]));
      // Back onto a rising edge so the next bus task drives right after it.
      @(posedge clk_sys);
   endtask
   // Reset values, and a write to an odd offset must not reach polarity.
   task automatic t_reset;
      logic [7:0] ra [6] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h08, 8'h01};
      wr(8'h05, 16'hFFFF);
      foreach (ra[i]) rd(ra[i], 16'h0000);
   endtask
   task automatic t_edge;
      cfg(0, 16'h0003, 16'h0002);
      wr(8'h02, 16'h0001);
      wr(8'h00, 16'h0001);
      meas(40);
      ck(0, 16'h0000, 16'h0000);
      wr(8'h06, 16'h0014);
      meas(40);
      ck(0, 16'h0014, 16'h000A);
      wr(8'h30, 16'h0000);
      meas(40);
      ck(0, 16'h0028, 16'h0000);
      wr(8'h30, 16'h0005);
      meas(40);
      ck(0, 16'h0000, 16'h0000);
      wr(8'h30, 16'h0001);
      meas(40);
      ck(0, 16'h001E, 16'h000A);
      wr(8'h04, 16'h0001);
      meas(40);
      ck(0, 16'h000A, 16'h000A);
      wr(8'h04, 16'h0000);
   endtask
   task automatic t_center;
      wr(8'h00, 16'h0000);
      cfg(0, 16'h0003, 16'h0002);
      wr(8'h02, 16'h0011);
      wr(8'h00, 16'h0001);
      meas(40);
      ck(0, 16'h0014, 16'h0005);
   endtask
   // Both counters start together, so the AND is a quarter duty.
   task automatic t_burst;
      wr(8'h00, 16'h0000);
      cfg(0, 16'h0003, 16'h0002);
      cfg(1, 16'h0003, 16'h0003);
      wr(8'h02, 16'h0103);
      wr(8'h00, 16'h0003);
      meas(40);
      ck(0, 16'h000A, 16'h000A);
      ck(1, 16'h000A, 16'h000A);
      wr(8'h04, 16'h0001);
      meas(40);
      ck(0, 16'h001E, 16'h000A);
      wr(8'h04, 16'h0000);
   endtask
   task automatic t_single;
      wr(8'h00, 16'h0000);
      wr(8'h02, 16'h0404);
      cfg(2, 16'h0005, 16'h0003);
      mstart;
      wr(8'h00, 16'h0004);
      mend(20);
      ck(2, 16'h0003, 16'h0001);
      rd(8'h00, 16'h4000);
      wr(8'h00, 16'h0000);
      rd(8'h00, 16'h0000);
      mstart;
      wr(8'h00, 16'h0004);
      wr(8'h14, 16'h0005);
      mend(20);
      ck(2, 16'h0001, 16'h0001);
      rd(8'h00, 16'h4000);
   endtask
   task automatic t_presc;
      wr(8'h00, 16'h0000);
      cfg(3, 16'h0001, 16'h0001);
      wr(8'h02, 16'h0008);
      wr(8'h00, 16'h0088);
      repeat (200) @(posedge clk_sys);
      meas(256);
      ck(3, 16'h0080, 16'h0002);
   endtask
   // A low clock enable must freeze the pins and swallow a write.
   task automatic t_freeze;
      wr(8'h00, 16'h0000);
      cfg(0, 16'h0001, 16'h0001);
      wr(8'h02, 16'h0001);
      wr(8'h00, 16'h0001);
      repeat (8) @(posedge clk_sys);
      ce <= 1'b0;
      mstart;
      wr(8'h04, 16'h0001);
      mend(20);
      chk("loadRise", 16'h0000, 16'(rs[0]));
      @(posedge clk_sys);
      ce <= 1'b1;
      rd(8'h04, 16'h0000);
   endtask
   initial
   begin
      rst_n = 1'b0;
      ce = 1'b1;
      regAddr = 8'h00;
      regWdata = 16'h0000;
      regWr = 1'b0;
      regRd = 1'b0;
      clr = 1'b0;
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      t_reset;
      t_edge;
      t_center;
      t_burst;
      t_single;
      t_presc;
      t_freeze;
      test_done;
   end
   // The whole run needs well under two thousand cycles.
   initial
   begin
      repeat (6000) @(posedge clk_sys);
      failures++;
      test_done;
   end
endmodule // tb_top
`default_nettype wire
